// ==== spm_pkg.sv ====
// Package for the shunt power math datapath: register map, fields, reset values, timing.
// Assumes a 125 MHz core clock and a serial front end that decodes register addresses.
package spm_pkg;
  localparam logic [7:0]  ADDR_BUS_VOLTAGE    = 8'h02;
  localparam logic [7:0]  ADDR_POWER          = 8'h03;
  localparam logic [7:0]  ADDR_CURRENT        = 8'h04;
  localparam logic [7:0]  ADDR_CALIBRATION    = 8'h05;
  localparam int          OVF_BIT             = 0;
  localparam int          CONVERSION_READY_FLAG_BIT            = 1;
  localparam int          BUS_VALUE_LSB       = 3;
  localparam int          BUS_TOP_BIT         = 15;
  localparam int          CAL_UNUSED_BIT      = 0;
  localparam int          CURRENT_SHIFT       = 12;
  localparam logic [31:0] POWER_DIVISOR       = 32'h0000_1388;
  localparam logic [15:0] RESULT_RESET        = 16'h0000;
  localparam logic [15:0] CAL_RESET           = 16'h0000;
  localparam logic [15:0] CAL_WRITE_MASK      = 16'hFFFE;
  localparam logic [2:0]  MODE_POWER_DOWN     = 3'h0;
  localparam logic [2:0]  MODE_DISABLE        = 3'h4;
  localparam int          DIV_CYCLES          = 32;
  typedef enum logic [1:0] {SPM_IDLE, SPM_MUL, SPM_DIV, SPM_DONE} spm_state_e;
endpackage

// ==== spm_div_if.sv ====
// Interface between the math control and the power divider.
// Assumes one clock domain shared by both modules.
interface spm_div_if;
  logic        start;
  logic [31:0] dividend;
  logic        busy;
  logic        done;
  logic [31:0] quotient;
  modport ctrl (output start, output dividend, input busy, input done, input quotient);
  modport unit (input start, input dividend, output busy, output done, output quotient);
endinterface

// ==== spm_divider.sv ====
// Restoring divider of an unsigned 32-bit magnitude by the fixed power divisor.
// Assumes start is pulsed only while busy is low.
module spm_divider (
  input  wire logic  clk_in,
  input  wire logic  rst_in,
  spm_div_if.unit    div
);
  logic [31:0] rem_r, rem_nxt, quo_r, quo_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic        busy_r, busy_nxt, done_r, done_nxt;
  logic [32:0] trial;

  always_comb begin
    rem_nxt  = rem_r;
    quo_nxt  = quo_r;
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    trial    = 33'h0_0000_0000;
    if (div.start && !busy_r) begin
      rem_nxt  = 32'h0000_0000;
      quo_nxt  = div.dividend;
      cnt_nxt  = 6'(spm_pkg::DIV_CYCLES);
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      trial = {rem_r, quo_r[31]} - {1'b0, spm_pkg::POWER_DIVISOR};
      if (!trial[32]) begin
        rem_nxt = trial[31:0];
        quo_nxt = {quo_r[30:0], 1'b1};
      end else begin
        rem_nxt = {rem_r[30:0], quo_r[31]};
        quo_nxt = {quo_r[30:0], 1'b0};
      end
      cnt_nxt = cnt_r - 6'h01;
      if (cnt_r == 6'h01) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rem_r  <= 32'h0000_0000;
      quo_r  <= 32'h0000_0000;
      cnt_r  <= 6'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      rem_r  <= rem_nxt;
      quo_r  <= quo_nxt;
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign div.busy     = busy_r;
  assign div.done     = done_r;
  assign div.quotient = quo_r;
endmodule

// ==== spm_calibration.sv ====
// Calibration register with its void low bit.
// Assumes write strobes come from the register front end on the same clock.
module spm_calibration (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        wr_en_in,
  input  wire logic [15:0] wr_data_in,
  output logic      [15:0] cal_out
);
  logic [15:0] cal_r, cal_nxt;

  always_comb begin
    cal_nxt = cal_r;
    if (wr_en_in) begin
      cal_nxt = wr_data_in & spm_pkg::CAL_WRITE_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cal_r <= spm_pkg::CAL_RESET;
    end else begin
      cal_r <= cal_nxt;
    end
  end

  assign cal_out = cal_r;
endmodule

// ==== spm_math_top.sv ====
// Result computation and status for the current and power monitor.
// Assumes conversions, mode writes and register strobes arrive from same-clock logic.
// Summary of operation
// - Ready flag sets after all math completes.
// - Latest results always readable.
// - New mode write clears ready, except off.
// - Power register read clears ready flag.
// - Overflow flag marks out-of-range current or power.
// - Current equals shunt times calibration over 4096.
// - Power equals current times bus over 5000.
// - Current stored as 16-bit two's complement.
// - Power register 03h read-only, resets zero.
// - Current register 04h read-only, resets zero.
// - Calibration 05h bits 15..1 writable.
// - Calibration bit 0 always zero.
// - Calibration clears at reset.
// - Bus value starts at bit 3.
// - Bus register 02h holds reading and flags.
// - 16 V range forces bus top bit zero.
module spm_math_top (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        conv_valid_in,
  input  wire logic [15:0] shunt_value_in,
  input  wire logic [15:0] bus_sample_in,
  input  wire logic        bus_range_select_in,
  input  wire logic        mode_write_in,
  input  wire logic [2:0]  mode_value_in,
  input  wire logic        reg_read_in,
  input  wire logic        reg_write_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  output logic      [15:0] bus_voltage_out,
  output logic      [15:0] power_out,
  output logic      [15:0] current_out,
  output logic      [15:0] calibration_out,
  output logic             conversion_ready_flag_out,
  output logic             math_overflow_flag_out
);
  spm_div_if div ();

  spm_pkg::spm_state_e state_r, state_nxt;
  logic        [15:0] cur_r, cur_nxt;
  logic        [15:0] pwr_r, pwr_nxt;
  logic        [12:0] bus_r, bus_nxt;
  logic        [15:0] shunt_r, shunt_nxt;
  logic               conversion_ready_flag_r, conversion_ready_flag_nxt;
  logic               ovf_r, ovf_nxt;
  logic               cur_ovf_r, cur_ovf_nxt;
  logic        [15:0] rdata_r, rdata_nxt;
  logic        [15:0] cal;
  logic               cal_wr;
  logic signed [32:0] cur_prod;
  logic signed [32:0] cur_full;
  logic        [15:0] cur_mag;
  logic        [31:0] pwr_prod;
  logic               start;
  logic               calc_done;
  logic        [16:0] pwr_sat;

  // Saturate a signed value into 16 bits and report overflow.
  function automatic logic [16:0] sat16(input logic signed [32:0] v);
    if (v > 33'sd32767) begin
      sat16 = {1'b1, 16'h7FFF};
    end else if (v < -33'sd32768) begin
      sat16 = {1'b1, 16'h8000};
    end else begin
      sat16 = {1'b0, v[15:0]};
    end
  endfunction

  // Saturate an unsigned quotient into 16 bits and report overflow.
  function automatic logic [16:0] satu16(input logic [31:0] v);
    if (v > 32'h0000_FFFF) begin
      satu16 = {1'b1, 16'hFFFF};
    end else begin
      satu16 = {1'b0, v[15:0]};
    end
  endfunction

  // Address match shared by the write strobe, the read side effect and the read mux.
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
    addr_hit = (a == r);
  endfunction

  // Power-down and disable leave the ready flag alone; every other mode clears it.
  function automatic logic mode_clears(input logic [2:0] m);
    mode_clears = (m != spm_pkg::MODE_POWER_DOWN) && (m != spm_pkg::MODE_DISABLE);
  endfunction

  // Two's complement magnitude; the most negative code maps to 8000h, read as unsigned.
  function automatic logic [15:0] mag16(input logic [15:0] v);
    if (v[15]) begin
      mag16 = 16'(-v);
    end else begin
      mag16 = v;
    end
  endfunction

  assign cal_wr = reg_write_in && addr_hit(reg_addr_in, spm_pkg::ADDR_CALIBRATION);

  spm_calibration u_cal (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .wr_en_in   (cal_wr),
    .wr_data_in (reg_wdata_in),
    .cal_out    (cal)
  );

  spm_divider u_div (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .div    (div)
  );

  // Calibration bit 0 is always zero, so the full word is the value used.
  always_comb begin
    cur_prod = 33'($signed(shunt_r)) * $signed({17'h0_0000, cal});
    cur_full = cur_prod >>> spm_pkg::CURRENT_SHIFT;
    cur_mag  = mag16(cur_r);
    pwr_prod = 32'(cur_mag) * 32'(bus_r);
  end

  assign start          = (state_r == spm_pkg::SPM_MUL);
  assign div.start      = start;
  assign div.dividend   = pwr_prod;

  // Conversion engine: capture, current, then power through the shared divider.
  always_comb begin
    logic [16:0] s;
    s           = 17'h0_0000;
    state_nxt   = state_r;
    cur_nxt     = cur_r;
    pwr_nxt     = pwr_r;
    bus_nxt     = bus_r;
    shunt_nxt   = shunt_r;
    cur_ovf_nxt = cur_ovf_r;
    case (state_r)
      spm_pkg::SPM_IDLE: begin
        // A sample offered while busy is dropped; the last results stay readable.
        if (conv_valid_in) begin
          shunt_nxt = shunt_value_in;
          bus_nxt   = bus_sample_in[spm_pkg::BUS_TOP_BIT:spm_pkg::BUS_VALUE_LSB];
          if (!bus_range_select_in) begin
            bus_nxt[12] = 1'b0;
          end
          state_nxt = spm_pkg::SPM_DIV;
        end
      end
      spm_pkg::SPM_DIV: begin
        // Calibration is sampled here; a later write affects the next sample only.
        s           = sat16(cur_full);
        cur_nxt     = s[15:0];
        cur_ovf_nxt = s[16];
        state_nxt   = spm_pkg::SPM_MUL;
      end
      spm_pkg::SPM_MUL: begin
        // The divider takes its start pulse at the end of this cycle.
        state_nxt = spm_pkg::SPM_DONE;
      end
      spm_pkg::SPM_DONE: begin
        if (div.done) begin
          pwr_nxt   = pwr_sat[15:0];
          state_nxt = spm_pkg::SPM_IDLE;
        end
      end
      default: begin
        state_nxt = spm_pkg::SPM_IDLE;
      end
    endcase
  end

  // The divider reports done once, so this is a single-cycle completion strobe.
  assign calc_done = (state_r == spm_pkg::SPM_DONE) && div.done;
  assign pwr_sat   = satu16(div.quotient);

  // Status flags. A set on completion wins over a same-cycle clear, so a
  // finished conversion is never hidden from a host that polls at that moment.
  always_comb begin
    conversion_ready_flag_nxt = conversion_ready_flag_r;
    ovf_nxt  = ovf_r;
    if (calc_done) begin
      ovf_nxt  = cur_ovf_r || pwr_sat[16];
      conversion_ready_flag_nxt = 1'b1;
    end else begin
      if (mode_write_in && mode_clears(mode_value_in)) begin
        conversion_ready_flag_nxt = 1'b0;
      end
      if (reg_read_in && addr_hit(reg_addr_in, spm_pkg::ADDR_POWER)) begin
        conversion_ready_flag_nxt = 1'b0;
      end
    end
  end

  // Read data reflects the register contents before this cycle's side effects.
  always_comb begin
    rdata_nxt = 16'h0000;
    if (addr_hit(reg_addr_in, spm_pkg::ADDR_BUS_VOLTAGE)) begin
      rdata_nxt = {bus_r, 1'b0, conversion_ready_flag_r, ovf_r};
    end else if (addr_hit(reg_addr_in, spm_pkg::ADDR_POWER)) begin
      rdata_nxt = pwr_r;
    end else if (addr_hit(reg_addr_in, spm_pkg::ADDR_CURRENT)) begin
      rdata_nxt = cur_r;
    end else if (addr_hit(reg_addr_in, spm_pkg::ADDR_CALIBRATION)) begin
      rdata_nxt = cal;
    end
  end

  // Engine state and results.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r   <= spm_pkg::SPM_IDLE;
      cur_r     <= spm_pkg::RESULT_RESET;
      pwr_r     <= spm_pkg::RESULT_RESET;
      bus_r     <= 13'h0000;
      shunt_r   <= 16'h0000;
      cur_ovf_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cur_r     <= cur_nxt;
      pwr_r     <= pwr_nxt;
      bus_r     <= bus_nxt;
      shunt_r   <= shunt_nxt;
      cur_ovf_r <= cur_ovf_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      conversion_ready_flag_r <= 1'b0;
      ovf_r  <= 1'b0;
    end else begin
      conversion_ready_flag_r <= conversion_ready_flag_nxt;
      ovf_r  <= ovf_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // The mirror lags the register by one cycle so that the port comes from a flop.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      calibration_out <= spm_pkg::CAL_RESET;
    end else begin
      calibration_out <= cal;
    end
  end

  assign reg_rdata_out             = rdata_r;
  assign bus_voltage_out           = {bus_r, 1'b0, conversion_ready_flag_r, ovf_r};
  assign power_out                 = pwr_r;
  assign current_out               = cur_r;
  assign conversion_ready_flag_out = conversion_ready_flag_r;
  assign math_overflow_flag_out    = ovf_r;
endmodule

// ==== spm_math_monitor.sv ====
// Port checks for the power math top: flags, reset values, read path.
// Assumes a bind onto spm_math_top that shares its clock and reset.
module spm_math_monitor (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        conv_valid_in,
  input wire logic        mode_write_in,
  input wire logic [2:0]  mode_value_in,
  input wire logic        reg_read_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [15:0] bus_voltage_out,
  input wire logic [15:0] power_out,
  input wire logic [15:0] current_out,
  input wire logic [15:0] calibration_out,
  input wire logic        conversion_ready_flag_out,
  input wire logic        math_overflow_flag_out
);
  logic [5:0] quiet_r;
  logic [5:0] quiet_nxt;
  logic       idle;
  logic       off;
  assign idle = quiet_r == 6'h3F;
  assign off = mode_value_in == 3'h0 || mode_value_in == 3'h4;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // A computation ends well inside 63 cycles of its start, so a clear seen later
  // cannot race a flag set, which would win.
  always_comb begin
    quiet_nxt = conv_valid_in ? 6'h00 : quiet_r + {5'h00, !idle};
  end
  always_ff @(posedge clk_in) begin
    quiet_r <= rst_in ? 6'h3F : quiet_nxt;
  end
  cal_lsb_a: assert property (calibration_out[0] == 1'b0)
    else $error("calibration bit 0 set");
  reset_zero_a: assert property ($past(rst_in) |-> (power_out | current_out | calibration_out) == 16'h0000)
    else $error("results not zero after reset");
  read_clear_a: assert property (idle && reg_read_in && reg_addr_in == 8'h03 |=> !conversion_ready_flag_out)
    else $error("ready kept after power read");
  mode_clear_a: assert property (idle && mode_write_in && !off |=> !conversion_ready_flag_out)
    else $error("ready kept after mode write");
  mode_keep_a: assert property (idle && mode_write_in && off && !reg_read_in && conversion_ready_flag_out |=> conversion_ready_flag_out)
    else $error("ready lost on power-down write");
  ready_late_a: assert property ($rose(conversion_ready_flag_out) |-> $stable(current_out))
    else $error("ready rose with current update");
  bus_flags_a: assert property (bus_voltage_out[2:0] == {1'b0, conversion_ready_flag_out, math_overflow_flag_out})
    else $error("bus word flag bits wrong");
  read_cur_a: assert property (reg_addr_in == 8'h04 |=> reg_rdata_out == $past(current_out))
    else $error("current read data wrong");
  ovf_done_a: assert property ($changed(math_overflow_flag_out) |-> conversion_ready_flag_out)
    else $error("overflow moved outside completion");
  cover property ($rose(conversion_ready_flag_out));
  cover property ($rose(math_overflow_flag_out));
  cover property (idle && mode_write_in && off);
endmodule

// ==== spm_host_model.sv ====
// Host model of the register reader: one-cycle strobes on the register port.
// Assumes read data is registered one cycle after the address is shown.
module spm_host_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] rdata_in,
  output logic             rd_out,
  output logic             wr_out,
  output logic             mode_wr_out,
  output logic [2:0]       mode_val_out,
  output logic [7:0]       addr_out,
  output logic [15:0]      wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {rd_out, wr_out, mode_wr_out, mode_val_out, addr_out, wdata_out} = 30'h0000_0000;
  end
  // Released address, data and mode value lines show the inverse and strobes drop to zero, so a stale value never passes for a held one.
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] wd,
                     output logic [15:0] rd);
    @(posedge clk_in);
    #1;
    {addr_out, wdata_out, rd_out, wr_out} = {a, wd, !w, w};
    @(posedge clk_in);
    #1;
    rd = rdata_in;
    {addr_out, wdata_out, rd_out, wr_out} = {~a, ~wd, 2'h0};
  endtask
  task automatic mode(input logic [2:0] v);
    @(posedge clk_in);
    #1;
    {mode_val_out, mode_wr_out} = {v, 1'b1};
    @(posedge clk_in);
    #1;
    {mode_val_out, mode_wr_out} = {~v, 1'b0};
  endtask
  task automatic volts(output logic [12:0] c);
    logic [15:0] d;
    acc(1'b0, 8'h02, 16'h0000, d);
    c = d[15:3];
  endtask
endmodule

// ==== shunt_power_math_datapath_bench.sv ====
// Self-checking bench for the power math top driven by a host register model.
// Assumes the design, the monitor and the host model are compiled first.
module shunt_power_math_datapath_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        conv_valid_in = 1'b0;
  logic        bus_range_select_in = 1'b1;
  logic [15:0] shunt_value_in = 16'h0000;
  logic [15:0] bus_sample_in = 16'h0000;
  logic        mode_write_in, reg_read_in, reg_write_in;
  logic [2:0]  mode_value_in;
  logic [7:0]  reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out, bus_voltage_out;
  logic [15:0] power_out, current_out, calibration_out;
  logic        conversion_ready_flag_out, math_overflow_flag_out;
  logic [12:0] c;
  int          n_mismatch = 0;
  int          compares = 0;
  always #4 clk_in = ~clk_in;
  spm_math_top spm_math_top_inst (.clk_in, .rst_in, .conv_valid_in, .shunt_value_in,
    .bus_sample_in, .bus_range_select_in, .mode_write_in, .mode_value_in, .reg_read_in,
    .reg_write_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .bus_voltage_out,
    .power_out, .current_out, .calibration_out, .conversion_ready_flag_out,
    .math_overflow_flag_out);
  spm_host_model spm_host_model_inst (.clk_in, .rdata_in(reg_rdata_out),
    .rd_out(reg_read_in), .wr_out(reg_write_in), .mode_wr_out(mode_write_in),
    .mode_val_out(mode_value_in), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));
  task automatic results();
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    spm_host_model_inst.acc(1'b0, a, 16'h0000, v);
    cmp(v, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic [15:0] u;
    spm_host_model_inst.acc(1'b1, a, v, u);
  endtask
  task automatic conv(input logic [15:0] s, input logic [15:0] b, input logic r,
                      input logic [15:0] cur);
    @(posedge clk_in);
    #1;
    {shunt_value_in, bus_sample_in, bus_range_select_in, conv_valid_in} = {s, b, r, 1'b1};
    @(posedge clk_in);
    #1;
    {shunt_value_in, bus_sample_in, conv_valid_in} = {~s, ~b, 1'b0};
    repeat (2) @(posedge clk_in);
    #1;
    cmp(current_out, cur);
    cmp({15'h0000, conversion_ready_flag_out}, 16'h0000);
    for (int i = 0; i < 80 && conversion_ready_flag_out !== 1'b1; i++) @(posedge clk_in);
    #1;
    cmp({15'h0000, conversion_ready_flag_out}, 16'h0001);
    repeat (30) @(posedge clk_in);
    #1;
  endtask
  task automatic t_reset();
    rd(8'h03, 16'h0000);
    rd(8'h04, 16'h0000);
    rd(8'h05, 16'h0000);
  endtask
  task automatic t_cal();
    wr(8'h05, 16'h5001);
    rd(8'h05, 16'h5000);
    cmp(calibration_out, 16'h5000);
    wr(8'h03, 16'h1234);
    rd(8'h03, 16'h0000);
  endtask
  task automatic t_example();
    conv(16'h07D0, 16'h5D98, 1'b1, 16'h2710);
    cmp(power_out, 16'h1766);
    cmp(bus_voltage_out, 16'h5D9A);
    spm_host_model_inst.volts(c);
    cmp({3'h0, c}, 16'h0BB3);
    rd(8'h04, 16'h2710);
    rd(8'h03, 16'h1766);
    cmp({15'h0000, conversion_ready_flag_out}, 16'h0000);
  endtask
  task automatic t_mode();
    conv(16'h07D0, 16'h5D98, 1'b1, 16'h2710);
    spm_host_model_inst.mode(3'h0);
    cmp({15'h0000, conversion_ready_flag_out}, 16'h0001);
    spm_host_model_inst.mode(3'h4);
    cmp({15'h0000, conversion_ready_flag_out}, 16'h0001);
    spm_host_model_inst.mode(3'h3);
    cmp({15'h0000, conversion_ready_flag_out}, 16'h0000);
  endtask
  task automatic t_neg();
    conv(16'hF830, 16'hDD98, 1'b0, 16'hD8F0);
    cmp(bus_voltage_out, 16'h5D9A);
    rd(8'h03, 16'h1766);
  endtask
  task automatic t_ovf();
    wr(8'h05, 16'hFFFE);
    conv(16'h7FFF, 16'h5D98, 1'b1, 16'h7FFF);
    cmp({15'h0000, math_overflow_flag_out}, 16'h0001);
    wr(8'h05, 16'h5000);
    wr(8'h03, 16'h0000);
    spm_host_model_inst.mode(3'h1);
    conv(16'h07D0, 16'h5D98, 1'b1, 16'h2710);
    cmp({15'h0000, math_overflow_flag_out}, 16'h0000);
  endtask
  task automatic t_rerst();
    @(posedge clk_in);
    #1;
    rst_in = 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    rd(8'h02, 16'h0000);
    t_reset();
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    t_reset();
    t_cal();
    t_example();
    t_mode();
    t_neg();
    t_ovf();
    t_rerst();
    results();
  end
  initial begin
    #60000;
    n_mismatch++;
    results();
  end
endmodule
bind spm_math_top spm_math_monitor spm_math_monitor_inst (.clk_in, .rst_in, .conv_valid_in,
  .mode_write_in, .mode_value_in, .reg_read_in, .reg_addr_in, .reg_rdata_out,
  .bus_voltage_out, .power_out, .current_out, .calibration_out,
  .conversion_ready_flag_out, .math_overflow_flag_out);
